// File: verilog/sdcr_pkg.sv
// Package for the delta-sigma converter control block
`default_nettype none
package sdcr_pkg;
  localparam logic [3:0] ADDR_CONTROL    = 4'h0;
  localparam logic [3:0] ADDR_START      = 4'h1;
  localparam logic [3:0] ADDR_BANDGAP    = 4'h2;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h3;
  localparam logic [3:0] ADDR_IRQ_MASK   = 4'h4;
  localparam logic [7:0] CONTROL_RESET   = 8'h00;
  localparam int MODE_BIT    = 7;
  localparam int OVS_LSB     = 4;
  localparam int REF_LSB     = 2;
  localparam int GAIN_LSB    = 0;
  localparam int START_BIT   = 7;
  localparam int BGR_RUN_BIT = 7;
  localparam logic [8:0] OVERSAMPLE_RATIO = 9'h140;
  localparam logic [1:0] REF_PORT = 2'h0;
  localparam logic [1:0] REF_EXT  = 2'h1;
  localparam logic [1:0] REF_INT  = 2'h3;
  localparam logic [2:0] OVS_MAX  = 3'h5;
endpackage : sdcr_pkg
`default_nettype wire

// File: verilog/sdcr_clkdiv.sv
// Oversampling clock-enable divider, divide by 2^code for codes 0 to 5, by 32 for codes 6 and 7
`default_nettype none
module sdcr_clkdiv (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic [2:0] div_code_in,
  output logic            tick_out
);
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic       tick_nxt;
  logic       tick_r;
  logic [4:0] limit;

  always_comb begin
    limit = 5'((6'h01 << div_code_in) - 6'h01);
    if (cnt_r >= limit) begin
      cnt_nxt  = 5'h00;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt  = cnt_r + 5'h01;
      tick_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r  <= 5'h00;
      tick_r <= 1'b0;
    end else if (ce_in) begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_out = tick_r;
endmodule : sdcr_clkdiv
`default_nettype wire

// File: verilog/sdcr_top.sv
// Control register logic of the delta-sigma converter
`default_nettype none
module sdcr_top (
  input  wire logic       CORE_CLK_IN,
  input  wire logic       RST_N_IN,
  input  wire logic       CE_IN,
  input  wire logic [3:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  input  wire logic       WR_IN,
  input  wire logic       RD_IN,
  input  wire logic       LOW_POWER_IN,
  output logic [7:0]      RDATA_OUT,
  output logic            IRQ_OUT,
  output logic            CONTINUOUS_OUT,
  output logic            CONVERTING_OUT,
  output logic            DONE_PULSE_OUT,
  output logic            OVS_TICK_OUT,
  output logic [2:0]      OVS_DIV_OUT,
  output logic            PIN_PORT_IN_OUT,
  output logic            PIN_REF_IN_OUT,
  output logic            PIN_REF_OUT_OUT,
  output logic            REFGEN_EXT_OUT,
  output logic            REFGEN_INT_OUT,
  output logic [1:0]      GAIN_OUT,
  output logic            BANDGAP_RUN_OUT
);
  typedef enum logic [2:0] {
    SDCR_IDLE = 3'b001,
    SDCR_CONV = 3'b010,
    SDCR_DONE = 3'b100
  } sdcr_state_t;

  logic [7:0]  control_r;
  logic [7:0]  control_nxt;
  logic        start_r;
  logic        start_nxt;
  logic        bgr_run_r;
  logic        bgr_run_nxt;
  logic        irq_stat_r;
  logic        irq_stat_nxt;
  logic        irq_mask_r;
  logic        irq_mask_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic        irq_r;
  logic        lp_s1_r;
  logic        lp_s2_r;
  sdcr_state_t state_r;
  sdcr_state_t state_nxt;
  logic [8:0]  samp_r;
  logic [8:0]  samp_nxt;
  logic        done_r;
  logic        done_nxt;
  logic        ovs_tick;
  logic [1:0]  ref_sel_nxt;
  logic        cont_mode;
  logic        irq_nxt;
  logic        lp_s1_nxt;
  logic        lp_s2_nxt;
  logic        pin_port_r;
  logic        pin_port_nxt;
  logic        pin_ref_in_r;
  logic        pin_ref_in_nxt;
  logic        pin_ref_out_r;
  logic        pin_ref_out_nxt;
  logic        refgen_ext_r;
  logic        refgen_ext_nxt;
  logic        refgen_int_r;
  logic        refgen_int_nxt;

  function automatic logic wr_hit(input logic [3:0] a);
    wr_hit = WR_IN && (ADDR_IN == a);
  endfunction

  // Pin function and reference source for one reference code:
  // port input, reference input, reference output, external source, internal source
  function automatic logic [4:0] ref_route(input logic [1:0] code);
    ref_route = {code == sdcr_pkg::REF_PORT, code == sdcr_pkg::REF_EXT, code[1],
                 code == sdcr_pkg::REF_EXT, code == sdcr_pkg::REF_INT};
  endfunction

  assign cont_mode = control_r[sdcr_pkg::MODE_BIT];

  // Oversampling enable from the divider field
  sdcr_clkdiv u_div (
    .clk_in      (CORE_CLK_IN),
    .rst_n_in    (RST_N_IN),
    .ce_in       (CE_IN),
    .div_code_in (control_r[sdcr_pkg::OVS_LSB +: 3]),
    .tick_out    (ovs_tick)
  );

  // Configuration registers
  always_comb begin
    control_nxt  = control_r;
    bgr_run_nxt  = bgr_run_r;
    irq_mask_nxt = irq_mask_r;
    if (wr_hit(sdcr_pkg::ADDR_CONTROL)) begin
      control_nxt = WDATA_IN;
    end
    if (lp_s2_r) begin
      control_nxt[sdcr_pkg::MODE_BIT] = 1'b0;
    end
    if (wr_hit(sdcr_pkg::ADDR_BANDGAP)) begin
      bgr_run_nxt = WDATA_IN[sdcr_pkg::BGR_RUN_BIT];
    end
    if (wr_hit(sdcr_pkg::ADDR_IRQ_MASK)) begin
      irq_mask_nxt = WDATA_IN[0];
    end
  end

  // Start bit and interrupt status
  always_comb begin
    start_nxt    = start_r;
    irq_stat_nxt = irq_stat_r;
    if (wr_hit(sdcr_pkg::ADDR_START) && WDATA_IN[sdcr_pkg::START_BIT]) begin
      start_nxt = 1'b1;
    end
    if (done_r && !cont_mode) begin
      start_nxt = 1'b0;
    end
    if (wr_hit(sdcr_pkg::ADDR_IRQ_STATUS) && WDATA_IN[0]) begin
      irq_stat_nxt = 1'b0;
    end
    if (done_r) begin
      irq_stat_nxt = 1'b1;
    end
    irq_nxt = irq_stat_nxt && irq_mask_nxt;
  end

  // Conversion sequencing
  always_comb begin
    state_nxt = state_r;
    samp_nxt  = samp_r;
    done_nxt  = 1'b0;
    unique case (state_r)
      SDCR_IDLE: begin
        samp_nxt = 9'h000;
        if ((cont_mode || start_r) && !lp_s2_r) begin
          state_nxt = SDCR_CONV;
        end
      end
      SDCR_CONV: begin
        if (lp_s2_r || (!cont_mode && !start_r)) begin
          state_nxt = SDCR_IDLE;
        end else if (ovs_tick) begin
          if (samp_r == sdcr_pkg::OVERSAMPLE_RATIO - 9'h001) begin
            state_nxt = SDCR_DONE;
            done_nxt  = 1'b1;
          end else begin
            samp_nxt = samp_r + 9'h001;
          end
        end
      end
      SDCR_DONE: begin
        samp_nxt  = 9'h000;
        state_nxt = (cont_mode && !lp_s2_r) ? SDCR_CONV : SDCR_IDLE;
      end
      default: begin
        state_nxt = SDCR_IDLE;
        samp_nxt  = 9'h000;
      end
    endcase
  end

  // Read data
  always_comb begin
    rdata_nxt = 8'h00;
    if (RD_IN) begin
      unique case (ADDR_IN)
        sdcr_pkg::ADDR_CONTROL:    rdata_nxt = control_r;
        sdcr_pkg::ADDR_START:      rdata_nxt = {start_r, state_r != SDCR_IDLE, 6'h00};
        sdcr_pkg::ADDR_BANDGAP:    rdata_nxt = {bgr_run_r, 7'h00};
        sdcr_pkg::ADDR_IRQ_STATUS: rdata_nxt = {7'h00, irq_stat_r};
        sdcr_pkg::ADDR_IRQ_MASK:   rdata_nxt = {7'h00, irq_mask_r};
        default:                   rdata_nxt = 8'h00;
      endcase
    end
  end

  // Decoded from the next control value, so internal routing and pin drive
  // switch together on the edge that takes the write
  always_comb begin
    ref_sel_nxt = control_nxt[sdcr_pkg::REF_LSB +: 2];
    {pin_port_nxt, pin_ref_in_nxt, pin_ref_out_nxt, refgen_ext_nxt, refgen_int_nxt} =
      ref_route(ref_sel_nxt);
  end

  // Low-power request crosses in through two flops;
  // only the second one is read by the sequencing logic
  always_comb begin
    lp_s1_nxt = LOW_POWER_IN;
    lp_s2_nxt = lp_s1_r;
  end

  // Configuration registers
  // Low power clears only the mode bit; the other fields are kept
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      control_r  <= sdcr_pkg::CONTROL_RESET;
      bgr_run_r  <= 1'b0;
      irq_mask_r <= 1'b0;
    end else if (CE_IN) begin
      control_r  <= control_nxt;
      bgr_run_r  <= bgr_run_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // Start bit and interrupt status
  // The interrupt level follows status and mask without an extra cycle
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      start_r    <= 1'b0;
      irq_stat_r <= 1'b0;
      irq_r      <= 1'b0;
    end else if (CE_IN) begin
      start_r    <= start_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_r      <= irq_nxt;
    end
  end

  // Conversion sequencer
  // A conversion spans the full oversampling ratio; done stands one cycle
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_r <= SDCR_IDLE;
      samp_r  <= 9'h000;
      done_r  <= 1'b0;
    end else if (CE_IN) begin
      state_r <= state_nxt;
      samp_r  <= samp_nxt;
      done_r  <= done_nxt;
    end
  end

  // Read data stand for the cycle after the read strobe
  // and are zero otherwise
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rdata_r <= 8'h00;
    end else if (CE_IN) begin
      rdata_r <= rdata_nxt;
    end
  end

  // Low-power synchroniser
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      lp_s1_r <= 1'b0;
      lp_s2_r <= 1'b0;
    end else if (CE_IN) begin
      lp_s1_r <= lp_s1_nxt;
      lp_s2_r <= lp_s2_nxt;
    end
  end

  // Pin function and reference routing
  // Reset value follows the reset control code
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      {pin_port_r, pin_ref_in_r, pin_ref_out_r, refgen_ext_r, refgen_int_r} <=
        ref_route(sdcr_pkg::CONTROL_RESET[sdcr_pkg::REF_LSB +: 2]);
    end else if (CE_IN) begin
      pin_port_r    <= pin_port_nxt;
      pin_ref_in_r  <= pin_ref_in_nxt;
      pin_ref_out_r <= pin_ref_out_nxt;
      refgen_ext_r  <= refgen_ext_nxt;
      refgen_int_r  <= refgen_int_nxt;
    end
  end

  // Every output comes straight from a register bit
  assign RDATA_OUT       = rdata_r;
  assign IRQ_OUT         = irq_r;
  assign CONTINUOUS_OUT  = cont_mode;
  assign CONVERTING_OUT  = state_r[1];
  assign DONE_PULSE_OUT  = done_r;
  assign OVS_TICK_OUT    = ovs_tick;
  assign OVS_DIV_OUT     = control_r[sdcr_pkg::OVS_LSB +: 3];
  assign PIN_PORT_IN_OUT = pin_port_r;
  assign PIN_REF_IN_OUT  = pin_ref_in_r;
  assign PIN_REF_OUT_OUT = pin_ref_out_r;
  assign REFGEN_EXT_OUT  = refgen_ext_r;
  assign REFGEN_INT_OUT  = refgen_int_r;
  assign GAIN_OUT        = control_r[sdcr_pkg::GAIN_LSB +: 2];
  assign BANDGAP_RUN_OUT = bgr_run_r;
endmodule : sdcr_top
`default_nettype wire

// File: sim/sdcr_analog_model.sv
// Behavioural model of the analog reference path
`default_nettype none
module sdcr_analog_model (
  input  wire logic refgen_ext_in,
  input  wire logic refgen_int_in,
  input  wire logic bandgap_run_in,
  output logic      ref_ok_out
);
  // Reference usable from the pin or from a running bandgap
  assign ref_ok_out = refgen_ext_in | (refgen_int_in & bandgap_run_in);
endmodule // sdcr_analog_model
`default_nettype wire

// File: sim/sdcr_top_assertions.sv
// Checker for the converter control block
`default_nettype none
module sdcr_checker (
  input wire logic       CORE_CLK_IN,
  input wire logic       RST_N_IN,
  input wire logic       CE_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic       WR_IN,
  input wire logic       RD_IN,
  input wire logic       LOW_POWER_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic       IRQ_OUT,
  input wire logic       CONTINUOUS_OUT,
  input wire logic       CONVERTING_OUT,
  input wire logic       DONE_PULSE_OUT,
  input wire logic       OVS_TICK_OUT,
  input wire logic [2:0] OVS_DIV_OUT,
  input wire logic       PIN_REF_IN_OUT,
  input wire logic       PIN_REF_OUT_OUT,
  input wire logic       REFGEN_EXT_OUT,
  input wire logic       REFGEN_INT_OUT,
  input wire logic [1:0] GAIN_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic wr_ctl;
  logic lp_d1_r;
  logic lp_d2_r;
  assign wr_ctl = WR_IN && CE_IN && ADDR_IN == sdcr_pkg::ADDR_CONTROL;
  // Low power clears the mode bit three enabled cycles after the pin rises
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      lp_d1_r <= 1'b0;
      lp_d2_r <= 1'b0;
    end else if (CE_IN) begin
      lp_d1_r <= LOW_POWER_IN;
      lp_d2_r <= lp_d1_r;
    end
  end
  mode_follow_a: assert property (wr_ctl && !lp_d2_r
    |=> CONTINUOUS_OUT == $past(WDATA_IN[7])) else $error("mode bit mismatch");
  ovs_follow_a: assert property (wr_ctl |=> OVS_DIV_OUT == $past(WDATA_IN[6:4]))
    else $error("divider field mismatch");
  tick_spacing_a: assert property (
    OVS_TICK_OUT && OVS_DIV_OUT == 3'h1 && CE_IN && !WR_IN |=> !OVS_TICK_OUT)
    else $error("tick too early");
  ext_ref_a: assert property (REFGEN_EXT_OUT |-> PIN_REF_IN_OUT)
    else $error("external reference without pin input");
  int_ref_a: assert property (wr_ctl && WDATA_IN[3:2] == 2'h3
    |=> REFGEN_INT_OUT && PIN_REF_OUT_OUT) else $error("internal reference split");
  gain_follow_a: assert property (wr_ctl |=> GAIN_OUT == $past(WDATA_IN[1:0]))
    else $error("gain field mismatch");
  done_pulse_a: assert property (DONE_PULSE_OUT |=> !DONE_PULSE_OUT)
    else $error("done longer than one cycle");
  low_power_a: assert property ((LOW_POWER_IN && CE_IN) [*5]
    |=> !CONTINUOUS_OUT && !CONVERTING_OUT) else $error("low power did not stop");
  reset_clear_a: assert property ($rose(RST_N_IN)
    |-> !CONTINUOUS_OUT && OVS_DIV_OUT == 3'h0 && GAIN_OUT == 2'h0) else $error("reset value");
  read_back_a: assert property (
    RD_IN && CE_IN && ADDR_IN == sdcr_pkg::ADDR_CONTROL
    |=> RDATA_OUT[7:4] == $past({CONTINUOUS_OUT, OVS_DIV_OUT})) else $error("read back");
  cover property (DONE_PULSE_OUT && CONTINUOUS_OUT);
  cover property ($rose(IRQ_OUT));
  cover property (REFGEN_INT_OUT);
endmodule // sdcr_checker
bind sdcr_top sdcr_checker u_chk (.CORE_CLK_IN, .RST_N_IN, .CE_IN, .ADDR_IN, .WDATA_IN,
  .WR_IN, .RD_IN, .LOW_POWER_IN, .RDATA_OUT, .IRQ_OUT, .CONTINUOUS_OUT, .CONVERTING_OUT,
  .DONE_PULSE_OUT, .OVS_TICK_OUT, .OVS_DIV_OUT, .PIN_REF_IN_OUT, .PIN_REF_OUT_OUT,
  .REFGEN_EXT_OUT, .REFGEN_INT_OUT, .GAIN_OUT);
`default_nettype wire

// File: sim/sdcr_top_tb.sv
// Testbench for the converter control block
`default_nettype none
module sdcr_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       lp = 1'b0;
  logic [7:0] rdata;
  logic [2:0] ovs;
  logic [1:0] gain;
  logic       irq, cont, conv, done, tick, pp, pi, po, re, ri, bg, ok;
  int         fail_count = 0;
  int         total_checks = 0;
  int         p;
  always #2.5 clk = ~clk;
  sdcr_top u_dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .LOW_POWER_IN(lp), .RDATA_OUT(rdata),
    .IRQ_OUT(irq), .CONTINUOUS_OUT(cont), .CONVERTING_OUT(conv), .DONE_PULSE_OUT(done),
    .OVS_TICK_OUT(tick), .OVS_DIV_OUT(ovs), .PIN_PORT_IN_OUT(pp), .PIN_REF_IN_OUT(pi),
    .PIN_REF_OUT_OUT(po), .REFGEN_EXT_OUT(re), .REFGEN_INT_OUT(ri), .GAIN_OUT(gain),
    .BANDGAP_RUN_OUT(bg));
  sdcr_analog_model u_ana (.refgen_ext_in(re), .refgen_int_in(ri), .bandgap_run_in(bg),
    .ref_ok_out(ok));
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
  endtask
  task automatic wait_for(input logic v, input int lim);
    int n;
    n = 0;
    while (((v ? done : tick) !== 1'b1) && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= lim) begin
      chk("wait bound", 8'h00, 8'h01);
      stop_test();
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(sdcr_pkg::ADDR_CONTROL);
    chk("control reset", sdcr_pkg::CONTROL_RESET, rdata);
    wr_reg(sdcr_pkg::ADDR_BANDGAP, 8'h80);
    chk("bandgap run", 8'h01, {7'h0, bg});
    for (int i = 0; i < 16; i++) begin
      wr_reg(sdcr_pkg::ADDR_CONTROL, {4'h0, i[3:0]});
      chk("pin and ref", {2'h0, i[3:2] != 2'h0 && i[3:2] != 2'h2, i[3:2] == 2'h0,
        i[3:2] == 2'h1, i[3], i[3:2] == 2'h1, i[3:2] == 2'h3},
        {2'h0, ok, pp, pi, po, re, ri});
      chk("gain", {6'h0, i[1:0]}, {6'h0, gain});
    end
    for (int c = 0; c < 6; c++) begin
      wr_reg(sdcr_pkg::ADDR_CONTROL, {1'b0, c[2:0], 4'h0});
      chk("divider", {5'h0, c[2:0]}, {5'h0, ovs});
      wait_for(1'b0, 80);
      p = 0;
      do begin
        @(posedge clk);
        #1;
        p++;
      end while (tick !== 1'b1 && p < 80);
      chk("tick period", 8'h01 << c, p[7:0]);
    end
    wr_reg(sdcr_pkg::ADDR_CONTROL, 8'h00);
    wr_reg(sdcr_pkg::ADDR_IRQ_MASK, 8'h01);
    wr_reg(sdcr_pkg::ADDR_START, 8'h80);
    wait_for(1'b1, 400);
    @(posedge clk);
    #1;
    chk("irq raised", 8'h01, {7'h0, irq});
    rd_reg(sdcr_pkg::ADDR_START);
    chk("start cleared", 8'h00, rdata & 8'hC0);
    wr_reg(sdcr_pkg::ADDR_IRQ_STATUS, 8'h01);
    @(posedge clk);
    #1;
    chk("irq cleared", 8'h00, {7'h0, irq});
    wr_reg(sdcr_pkg::ADDR_CONTROL, 8'h80);
    wait_for(1'b1, 400);
    @(posedge clk);
    #1;
    wait_for(1'b1, 400);
    chk("repeat", 8'h01, {7'h0, cont});
    @(posedge clk);
    #1;
    chk("next conversion", 8'h01, {7'h0, conv});
    @(posedge clk);
    lp <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk("low power stop", 8'h00, {6'h0, cont, conv});
    stop_test();
  end
endmodule // sdcr_top_tb
`default_nettype wire
